// *** sdram_ctrl_model.sv ***
// controller-side model: write data and data bus resolution
`timescale 1ns/100ps
`default_nettype none
module sdram_ctrl_model
(
  input wire logic clk_sys,
  input wire logic write_active,
  input wire logic [15:0] wdata,
  input wire logic [15:0] data_bus_pins_out,
  input wire logic [1:0] data_bus_pins_oe,
  output logic [15:0] data_bus_pins_in
);
  // ---
  // bus
  // ---
  // a free lane shows wdata while write is active, otherwise the inverse of its last level
  logic [15:0] last = 16'h0000;
  always @(negedge clk_sys)
    last <= data_bus_pins_in;
  always_comb
  begin
    data_bus_pins_in = write_active ? wdata : ~last;
    if (data_bus_pins_oe[0])
      data_bus_pins_in[7:0] = data_bus_pins_out[7:0];
    if (data_bus_pins_oe[1])
      data_bus_pins_in[15:8] = data_bus_pins_out[15:8];
  end
endmodule
`default_nettype wire

// *** sdram_pin_checker.sv ***
// assertions on the sdram control-pin front end
`timescale 1ns/100ps
`default_nettype none
module sdram_pin_checker
  import sdram_pin_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clock_enable,
  input wire logic chip_select_n,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic [1:0] data_bus_pins_oe,
  input wire logic read_active,
  input wire logic write_active,
  input wire logic cmd_valid,
  input wire sdram_pin_pkg::cmd_t cmd,
  input wire logic write_valid,
  input wire logic [1:0] write_byte_en,
  input wire sdram_pin_pkg::power_t power_state
);
  import sdram_pin_pkg::*;
  // ------
  // checks
  // ------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire take = clock_enable && !chip_select_n;
  wire [1:0] msk = {high_byte_mask, low_byte_mask};
  sequence valid3;
    clock_enable [*3];
  endsequence
  cmd_take_a: assert property (take |=> cmd_valid)
    else $error("command lost");
  cmd_hold_a: assert property (!take |=> !cmd_valid && $stable(cmd))
    else $error("command changed");
  cke_gate_a: assert property (!clock_enable |=>
    $stable(data_bus_pins_oe) && !write_valid) else $error("edge not gated");
  wr_mask_a: assert property (clock_enable && write_active |=>
    write_valid && write_byte_en == ~$past(msk)) else $error("write mask");
  wr_idle_a: assert property (!write_active |=> !write_valid)
    else $error("stray write");
  rd_mask_a: assert property (valid3 |=> data_bus_pins_oe ==
    ({2{$past(read_active)}} & ~$past(msk, 3))) else $error("read mask");
  pwr_low_a: assert property (!clock_enable [*5] |->
    power_state != PWR_RUN) else $error("no low power");
  pwr_run_a: assert property (clock_enable [*5] |->
    power_state == PWR_RUN) else $error("no run");
endmodule
bind sdram_pin_front sdram_pin_checker chk (.*);
`default_nettype wire

// *** sdram_pin_front.sv ***
// control-pin front end: command capture, clock gating, byte masking
`timescale 1ns/100ps
`default_nettype none

// How it works
// - every pin except clock enable is captured on the rising clk_sys edge.
// - an edge counts only while clock enable is high; otherwise the valid flags clear and command, mask and lane state hold.
// - with clock enable low the block reports power-down, suspend or self refresh.
// - clock enable is treated as asynchronous and synchronised for state tracking.
// - a command is taken only with chip select low; high disables command input.
// - with chip select high the held command state does not change.
// - the command is decoded from row, column and write strobe levels together.
// - the data bus is handled as two byte lanes, each with its own mask pin.
// - on reads a lane is driven when its mask is low and released when high.
// - on writes a byte is stored only when its mask is low.
// - a read mask sampled high releases its lane two valid edges later.
// - a write mask applies to the data presented in the same cycle.
module sdram_pin_front
  import sdram_pin_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clock_enable,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [sdram_pin_pkg::BANK_W-1:0] bank_pins,
  input wire logic [sdram_pin_pkg::ADDR_W-1:0] addr_pins,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic [DATA_W-1:0] data_bus_pins_in,
  output logic [DATA_W-1:0] data_bus_pins_out,
  output logic [sdram_pin_pkg::LANES-1:0] data_bus_pins_oe,
  input wire logic read_active,
  input wire logic write_active,
  input wire logic [DATA_W-1:0] read_data,
  output logic cmd_valid,
  output sdram_pin_pkg::cmd_t cmd,
  output logic [sdram_pin_pkg::BANK_W-1:0] cmd_bank,
  output logic [sdram_pin_pkg::ADDR_W-1:0] cmd_addr,
  output logic write_valid,
  output logic [DATA_W-1:0] write_data,
  output logic [sdram_pin_pkg::LANES-1:0] write_byte_en,
  output sdram_pin_pkg::power_t power_state
);
  import sdram_pin_pkg::*;

  if (DATA_W != LANES * LANE_W)
  begin : g_bad_width
    $error("DATA_W must be two byte lanes wide");
  end

  // ----------------------------------------------------------------
  // clock enable
  // ----------------------------------------------------------------
  // raw level gates the edge, as on the pin; the synchronised copy only
  // drives power-state tracking, so metastability cannot reach it
  logic edge_ok;
  logic cke_meta;
  logic cke_sync;
  assign edge_ok = clock_enable;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // reset high to agree with the run state: no false power-down
      cke_meta <= 1'b1;
      cke_sync <= 1'b1;
    end
    else
    begin
      cke_meta <= clock_enable;
      cke_sync <= cke_meta;
    end
  end

  // ----------------------------------------------------------------
  // command capture and decode
  // ----------------------------------------------------------------
  logic [LANES-1:0] mask_pins;
  logic [LANES-1:0] mask_d1;
  logic [LANES-1:0] mask_d2;
  cmd_t decoded;
  cmd_t next_cmd;
  logic next_cmd_valid;
  logic [BANK_W-1:0] next_cmd_bank;
  logic [ADDR_W-1:0] next_cmd_addr;

  assign mask_pins = {high_byte_mask, low_byte_mask};

  always_comb
  begin
    case ({row_strobe_n, col_strobe_n, write_strobe_n})
      CODE_MODE: decoded = CMD_MODE;
      CODE_REFRESH: decoded = CMD_REFRESH;
      CODE_PRECHARGE: decoded = CMD_PRECHARGE;
      CODE_ACTIVE: decoded = CMD_ACTIVE;
      CODE_WRITE: decoded = CMD_WRITE;
      CODE_READ: decoded = CMD_READ;
      CODE_BURST_STOP: decoded = CMD_BURST_STOP;
      default: decoded = CMD_NOP;
    endcase
  end

  always_comb
  begin
    next_cmd_valid = 1'b0;
    next_cmd = cmd;
    next_cmd_bank = cmd_bank;
    next_cmd_addr = cmd_addr;
    if (edge_ok && !chip_select_n)
    begin
      next_cmd_valid = 1'b1;
      next_cmd = decoded;
      next_cmd_bank = bank_pins;
      next_cmd_addr = addr_pins;
    end
    // chip select high: held values stay, strobes are ignored
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_valid <= 1'b0;
      cmd <= CMD_NOP;
      cmd_bank <= '0;
      cmd_addr <= '0;
    end
    else
    begin
      cmd_valid <= next_cmd_valid;
      cmd <= next_cmd;
      cmd_bank <= next_cmd_bank;
      cmd_addr <= next_cmd_addr;
    end
  end

  // ----------------------------------------------------------------
  // byte lanes
  // ----------------------------------------------------------------
  logic [LANES-1:0] next_mask_d1;
  logic [LANES-1:0] next_mask_d2;
  logic [LANES-1:0] next_oe;
  logic [LANES-1:0] next_byte_en;
  logic [DATA_W-1:0] next_out;
  logic [DATA_W-1:0] next_wdata;
  logic next_write_valid;

  always_comb
  begin
    next_mask_d1 = mask_d1;
    next_mask_d2 = mask_d2;
    next_out = data_bus_pins_out;
    next_write_valid = 1'b0;
    next_wdata = write_data;
    next_byte_en = write_byte_en;
    if (edge_ok)
    begin
      // two-stage mask pipe sets read release latency
      next_mask_d1 = mask_pins;
      next_mask_d2 = mask_d1;
      next_out = read_data;
      next_write_valid = write_active;
      next_wdata = data_bus_pins_in;
      next_byte_en = ~mask_pins;
    end
  end

  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    always_comb
    begin
      next_oe[i] = 1'b0;
      if (!edge_ok)
        next_oe[i] = data_bus_pins_oe[i];
      else if (read_active && !mask_d2[i])
        next_oe[i] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_d1 <= '1;
      mask_d2 <= '1;
      data_bus_pins_oe <= '0;
      data_bus_pins_out <= '0;
      write_valid <= 1'b0;
      write_data <= '0;
      write_byte_en <= '0;
    end
    else
    begin
      mask_d1 <= next_mask_d1;
      mask_d2 <= next_mask_d2;
      data_bus_pins_oe <= next_oe;
      data_bus_pins_out <= next_out;
      write_valid <= next_write_valid;
      write_data <= next_wdata;
      write_byte_en <= next_byte_en;
    end
  end

  // ----------------------------------------------------------------
  // low-power state
  // ----------------------------------------------------------------
  // self refresh is entered only by a refresh command with enable low
  power_t next_power;
  logic refresh_entry;
  assign refresh_entry = !chip_select_n && decoded == CMD_REFRESH;

  always_comb
  begin
    next_power = power_state;
    case (power_state)
      PWR_RUN:
      begin
        if (!cke_sync)
        begin
          if (refresh_entry)
            next_power = PWR_SELF_REFRESH;
          else if (read_active || write_active)
            next_power = PWR_SUSPEND;
          else
            next_power = PWR_DOWN;
        end
      end
      default:
      begin
        if (cke_sync)
          next_power = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      power_state <= PWR_RUN;
    else
      power_state <= next_power;
  end

endmodule

`default_nettype wire

// *** sdram_pin_pkg.sv ***
// constants and types shared by the sdram control-pin front end
`default_nettype none
package sdram_pin_pkg;

  localparam int LANE_W = 8;
  localparam int LANES = 2;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 12;
  // read mask to data-bus effect, in clock cycles
  localparam int READ_MASK_LAT = 2;

  // strobe combination {row, column, write}, all active low
  localparam logic [2:0] CODE_MODE = 3'h0;
  localparam logic [2:0] CODE_REFRESH = 3'h1;
  localparam logic [2:0] CODE_PRECHARGE = 3'h2;
  localparam logic [2:0] CODE_ACTIVE = 3'h3;
  localparam logic [2:0] CODE_WRITE = 3'h4;
  localparam logic [2:0] CODE_READ = 3'h5;
  localparam logic [2:0] CODE_BURST_STOP = 3'h6;
  localparam logic [2:0] CODE_NOP = 3'h7;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACTIVE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_REFRESH,
    CMD_MODE,
    CMD_BURST_STOP
  } cmd_t;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_DOWN,
    PWR_SUSPEND,
    PWR_SELF_REFRESH
  } power_t;

endpackage

`default_nettype wire

// *** test_sdram_pin_control_interface.sv ***
// self-checking bench for the sdram control-pin front end
`timescale 1ns/100ps
`default_nettype none
module test_sdram_pin_control_interface;
  import sdram_pin_pkg::*;
  logic clk_sys = 0, rst_n = 0, clock_enable = 1, chip_select_n = 1;
  logic row_strobe_n = 1, col_strobe_n = 1, write_strobe_n = 1;
  logic low_byte_mask = 1, high_byte_mask = 1, read_active = 0;
  logic write_active = 0, cmd_valid, write_valid, pk, ps, pw, pr;
  logic [1:0] bank_pins = 2'h0, data_bus_pins_oe, write_byte_en, cmd_bank;
  logic [1:0] h0, h1, pm, pbk;
  logic [11:0] addr_pins = 12'h000, cmd_addr, pad;
  logic [15:0] read_data = 16'h0000, wdata = 16'h0000, pb, prd;
  logic [15:0] data_bus_pins_in, data_bus_pins_out, write_data;
  logic [2:0] pc;
  cmd_t cmd;
  power_t power_state;
  cmd_t tbl [8] = '{CMD_MODE, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVE,
    CMD_WRITE, CMD_READ, CMD_BURST_STOP, CMD_NOP};
  int num_errors = 0, comparisons = 0, seed = 32'h472b, i;
  sdram_pin_front dut (.*);
  sdram_ctrl_model ctrl (.*);
  // -----
  // tasks
  // -----
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic logic [1:0] lane_oe(input logic r, input logic [1:0] m);
    return {2{r}} & ~m;
  endfunction
  task automatic check(input logic [17:0] seen, input logic [17:0] want);
    comparisons++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // inputs settle first, the edge lands, outputs are read at the fall
  task automatic step;
    #1;
    pk = clock_enable;
    ps = !chip_select_n;
    pc = {row_strobe_n, col_strobe_n, write_strobe_n};
    pw = write_active;
    pr = read_active;
    pm = {high_byte_mask, low_byte_mask};
    pb = data_bus_pins_in;
    prd = read_data;
    {pbk, pad} = {bank_pins, addr_pins};
    @(negedge clk_sys);
    check(cmd_valid, pk && ps);
    check(write_valid, pk && pw);
    if (pk && ps)
    begin
      check(cmd, tbl[pc]);
      check({cmd_bank, cmd_addr}, {pbk, pad});
    end
    if (pk && pw)
      check({write_byte_en, write_data}, {~pm, pb});
    if (pk)
    begin
      check(data_bus_pins_oe, lane_oe(pr, h1));
      check(data_bus_pins_out, prd);
      h1 = h0;
      h0 = pm;
    end
  endtask
  // ----
  // main
  // ----
  initial
  begin
    h0 = 2'h3;
    h1 = 2'h3;
    repeat (3) @(negedge clk_sys);
    rst_n = 1;
    // every strobe code first, then random pins with enable dropouts
    for (i = 0; i < 400; i++)
    begin
      clock_enable = (i < 8) || (($random(seed) & 7) != 0);
      chip_select_n = (i >= 8) && 1'($random(seed));
      {row_strobe_n, col_strobe_n, write_strobe_n} =
        i < 8 ? 3'(i) : 3'($random(seed));
      {bank_pins, addr_pins} = 14'($random(seed));
      {high_byte_mask, low_byte_mask} = 2'($random(seed));
      {read_active, write_active} = 2'($random(seed));
      {read_data, wdata} = $random(seed);
      step();
    end
    chip_select_n = 1;
    read_active = 0;
    // last pass holds a refresh command while enable drops
    for (i = 0; i < 3; i++)
    begin
      clock_enable = 1;
      chip_select_n = (i != 2);
      {row_strobe_n, col_strobe_n, write_strobe_n} = CODE_REFRESH;
      repeat (6) @(negedge clk_sys);
      check(power_state, PWR_RUN);
      write_active = 1'(i);
      clock_enable = 0;
      repeat (6) @(negedge clk_sys);
      check(power_state, i == 2 ? PWR_SELF_REFRESH :
        (i ? PWR_SUSPEND : PWR_DOWN));
    end
    end_of_test();
  end
endmodule
`default_nettype wire
